// ---- logic/flow_through_sync_sram_port.sv ----
// Flow-through synchronous burst SRAM port: registered inputs, burst
// counter, self-timed late writes, output drive control, read stream.
// Assumes all pin inputs are synchronous to clk.
`timescale 1ns/100ps

module flow_through_sync_sram_port #(
    parameter int LANES = sram_port_pkg::LANES_WIDE,
    parameter int ADDR_W = sram_port_pkg::ADDR_BITS_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Address and control pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic write_sel_n,
    input wire logic [LANES-1:0] lane_write_n,
    input wire logic advance_or_load,
    input wire logic clock_qualify_n,
    input wire logic burst_interleave,
    input wire logic output_enable_n,
    input wire logic sleep_pin,
    // Data pins
    input wire logic [LANES*sram_port_pkg::LANE_BITS-1:0] dq_in,
    output logic [LANES*sram_port_pkg::LANE_BITS-1:0] dq_out,
    output logic dq_oe,
    // Read data stream
    output logic [LANES*sram_port_pkg::LANE_BITS-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    // Status
    output logic stream_ready,
    output logic power_down
);

    localparam int WORD_W = LANES * sram_port_pkg::LANE_BITS;
    localparam int BB = sram_port_pkg::BURST_BITS;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (!(LANES == sram_port_pkg::LANES_WIDE ||
          LANES == sram_port_pkg::LANES_NARROW) || ADDR_W <= BB) begin : g_chk
        $error("Unsupported lane count or address width");
    end

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic [BB-1:0] burst_next(
        input logic [BB-1:0] base,
        input logic [BB-1:0] step,
        input logic interleave
    );
        logic [BB-1:0] s;
        s = step + 2'h1;
        burst_next = interleave ? (base ^ s) : (base + s);
    endfunction : burst_next

    function automatic logic selected(
        input logic s1_n,
        input logic s2,
        input logic s3_n
    );
        selected = !s1_n && s2 && !s3_n;
    endfunction : selected

    logic run;
    logic buf_in_ready;
    logic sel_now;
    logic act_q, act_d;
    logic wr_q, wr_d;
    logic desel_q, desel_d;
    logic [LANES-1:0] lanes_q, lanes_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [BB-1:0] base_q, base_d;
    logic [BB-1:0] step_q, step_d;
    logic [WORD_W-1:0] array_rd;
    logic wr_en;

    // Back-pressure of the read stream suspends the port like the qualifier
    assign run = !clock_qualify_n && buf_in_ready;
    assign sel_now = selected(chip_sel1_n, chip_sel2, chip_sel3_n)
                     && !sleep_pin;

    // ------------------------------------------------------------
    // Next access: load or burst advance
    // ------------------------------------------------------------
    always_comb begin
        act_d = act_q;
        wr_d = wr_q;
        desel_d = desel_q;
        lanes_d = lanes_q;
        addr_d = addr_q;
        base_d = base_q;
        step_d = step_q;
        if (!advance_or_load) begin
            act_d = sel_now;
            desel_d = !sel_now;
            wr_d = !write_sel_n;
            lanes_d = ~lane_write_n;
            addr_d = addr;
            base_d = addr[BB-1:0];
            step_d = sram_port_pkg::BURST_STEP_RESET;
        end else if (act_q) begin
            // Lane selects are taken fresh on every beat of a burst
            lanes_d = ~lane_write_n;
            step_d = step_q + 2'h1;
            addr_d[BB-1:0] = burst_next(base_q, step_q,
                                        burst_interleave);
        end
        if (sleep_pin) begin
            act_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            desel_q <= 1'b1;
            lanes_q <= '0;
            addr_q <= '0;
            base_q <= sram_port_pkg::BURST_STEP_RESET;
            step_q <= sram_port_pkg::BURST_STEP_RESET;
        end else if (run) begin
            act_q <= act_d;
            wr_q <= wr_d;
            desel_q <= desel_d;
            lanes_q <= lanes_d;
            addr_q <= addr_d;
            base_q <= base_d;
            step_q <= step_d;
        end
    end

    // ------------------------------------------------------------
    // Array: late write and flow-through read
    // ------------------------------------------------------------
    // Write data lands one qualified edge after its address; the array
    // commits it on that edge with no strobe from the controller
    assign wr_en = run && act_q && wr_q;

    sram_word_array #(
        .LANES(LANES),
        .LANE_W(sram_port_pkg::LANE_BITS),
        .ADDR_W(ADDR_W)
    ) u_array (
        .clk(clk),
        .wr_en(wr_en),
        .rd_en(run),
        .wr_addr(addr_q),
        .wr_lanes(lanes_q),
        .wr_data(dq_in),
        .rd_addr(addr_d),
        .rd_data(array_rd)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign dq_out = array_rd;
    // Drivers follow the access type on their own; output enable only
    // masks them and never needs toggling for turnarounds
    assign dq_oe = act_q && !wr_q && !output_enable_n
                   && !sleep_pin;
    assign power_down = sleep_pin || desel_q;
    assign stream_ready = buf_in_ready;

    // ------------------------------------------------------------
    // Two-entry read buffer
    // ------------------------------------------------------------
    logic [WORD_W-1:0] buf_q [0:1];
    logic [1:0] cnt_q;
    logic rd_q;
    logic push, pop;

    assign buf_in_ready = (cnt_q < sram_port_pkg::BUF_DEPTH) || rd_ready;
    assign push = run && act_q && !wr_q;
    assign pop = rd_valid && rd_ready;
    assign rd_valid = (cnt_q != sram_port_pkg::BUF_COUNT_RESET);
    assign rd_data = buf_q[0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= sram_port_pkg::BUF_COUNT_RESET;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (pop) begin
            buf_q[0] <= (cnt_q == 2'h2) ? buf_q[1] : array_rd;
            if (push) begin
                buf_q[cnt_q == 2'h2 ? 1 : 0] <= array_rd;
            end
        end else if (push) begin
            buf_q[cnt_q[0]] <= array_rd;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    assign rd_q = act_q && !wr_q;

    sequence s_load_sel;
        run && !advance_or_load && sel_now;
    endsequence

    sequence s_beat;
        run && advance_or_load && act_q;
    endsequence

    sequence s_write_load;
        run && !advance_or_load && sel_now && !write_sel_n;
    endsequence

    property p_write_float;
        @(posedge clk) disable iff (reset) s_write_load |=> !dq_oe;
    endproperty
    a_write_float: assert property (p_write_float)
        else $error("Data drivers on during write phase");

    property p_oe_gate;
        @(posedge clk) disable iff (reset) output_enable_n |-> !dq_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("Output enable did not gate drivers");

    property p_hold;
        @(posedge clk) disable iff (reset)
            clock_qualify_n |=> $stable(addr_q) && $stable(act_q)
                                && $stable(step_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("State moved on an unqualified edge");

    property p_read_flow;
        @(posedge clk) disable iff (reset)
            (s_load_sel and write_sel_n)
            |=> rd_q ##0 (dq_oe || output_enable_n || sleep_pin);
    endproperty
    a_read_flow: assert property (p_read_flow)
        else $error("Read data not presented after address edge");

    property p_no_wait;
        @(posedge clk) disable iff (reset)
            s_load_sel ##1 s_load_sel |-> act_q && addr_q == $past(addr);
    endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("Back-to-back load not taken");

    property p_deselect;
        @(posedge clk) disable iff (reset)
            (run && !advance_or_load && !sel_now) |=> !act_q && power_down;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("Access started while deselected");

    property p_linear;
        @(posedge clk) disable iff (reset)
            (s_beat and !burst_interleave)
            |=> addr_q[1:0] == $past(addr_q[1:0]) + 2'h1;
    endproperty
    a_linear: assert property (p_linear)
        else $error("Linear burst address wrong");

    property p_seed;
        @(posedge clk) disable iff (reset)
            s_load_sel |=> addr_q == $past(addr) && step_q == 2'h0
                           && base_q == $past(addr[1:0]);
    endproperty
    a_seed: assert property (p_seed)
        else $error("Burst counter not seeded from address");

    property p_sleep;
        @(posedge clk) disable iff (reset)
            sleep_pin |-> power_down && !dq_oe;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep did not power down");

    property p_turn;
        @(posedge clk) disable iff (reset)
            (run && act_q && wr_q && !advance_or_load && sel_now
             && write_sel_n) |-> wr_en ##1 rd_q;
    endproperty
    a_turn: assert property (p_turn)
        else $error("Dead cycle on write to read turnaround");

    property p_wr_commit;
        @(posedge clk) disable iff (reset)
            s_write_load ##1 run |-> wr_en;
    endproperty
    a_wr_commit: assert property (p_wr_commit)
        else $error("Write data phase did not commit");

    property p_suspend_out;
        @(posedge clk) disable iff (reset)
            clock_qualify_n |=> $stable(dq_out);
    endproperty
    a_suspend_out: assert property (p_suspend_out)
        else $error("Read data moved on an unqualified edge");

    property p_step_adv;
        @(posedge clk) disable iff (reset)
            s_beat |=> step_q == $past(step_q) + 2'h1;
    endproperty
    a_step_adv: assert property (p_step_adv)
        else $error("Burst step did not advance");

    property p_interleave;
        @(posedge clk) disable iff (reset)
            (s_beat and burst_interleave)
            |=> addr_q[1:0] == ($past(base_q) ^ ($past(step_q) + 2'h1));
    endproperty
    a_interleave: assert property (p_interleave)
        else $error("Interleaved burst address wrong");

    property p_upper_fixed;
        @(posedge clk) disable iff (reset)
            s_beat |=> addr_q[ADDR_W-1:BB] == $past(addr_q[ADDR_W-1:BB]);
    endproperty
    a_upper_fixed: assert property (p_upper_fixed)
        else $error("Burst moved the upper address bits");

    property p_lane_fresh;
        @(posedge clk) disable iff (reset)
            s_beat |=> lanes_q == ~$past(lane_write_n);
    endproperty
    a_lane_fresh: assert property (p_lane_fresh)
        else $error("Lane selects not taken on a burst beat");

    property p_push;
        @(posedge clk) disable iff (reset)
            (run && rd_q && !pop) |=> cnt_q == $past(cnt_q) + 2'h1;
    endproperty
    a_push: assert property (p_push)
        else $error("Read data phase not queued");

    property p_power_up;
        @(posedge clk) disable iff (reset)
            s_load_sel |=> !power_down || sleep_pin;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("Selected load left the port powered down");

endmodule : flow_through_sync_sram_port

// ---- logic/sram_word_array.sv ----
// Storage array with per-lane write enables and a registered read port.
// Assumes the caller gates both ports with its own run condition.
`timescale 1ns/100ps

module sram_word_array #(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter int ADDR_W = 10
) (
    // Clock and strobes
    input wire logic clk,
    input wire logic wr_en,
    input wire logic rd_en,
    // Write port
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [LANES-1:0] wr_lanes,
    input wire logic [LANES*LANE_W-1:0] wr_data,
    // Read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data
);

    if (LANES < 1 || LANE_W < 1 || ADDR_W < 1) begin : g_chk
        $error("Unsupported array shape");
    end

    // ------------------------------------------------------------
    // Lane writes and read with write-through
    // ------------------------------------------------------------
    // Forwarding makes a read right after a write to the same word see
    // the new lanes, so turnarounds need no dead cycle
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        // One store per lane, so every lane store has a single writing process
        logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

        always_ff @(posedge clk) begin
            if (wr_en && wr_lanes[l]) begin
                mem[wr_addr] <= wr_data[l*LANE_W +: LANE_W];
            end
            if (rd_en) begin
                if (wr_en && wr_lanes[l] && wr_addr == rd_addr) begin
                    rd_data[l*LANE_W +: LANE_W] <=
                        wr_data[l*LANE_W +: LANE_W];
                end else begin
                    rd_data[l*LANE_W +: LANE_W] <= mem[rd_addr];
                end
            end
        end
    end

endmodule : sram_word_array

// ---- shared/sram_port_pkg.sv ----
// Constants for the flow-through synchronous burst SRAM port.
// Assumes one clock; the port module refers to names here by package scope.
//
// Operation
// - All synchronous inputs are captured on the rising clock edge.
// - Clock qualifier high: edge ignored, port state holds unchanged; the read buffer can still drain.
// - Back-to-back reads or writes, one per clock, no wait states.
// - No idle cycle on write-to-read or read-to-write turnaround.
// - Data word is 36 bits wide or 18 bits narrow, in byte lanes.
// - Write select plus per-lane selects; only selected lanes update.
// - Writes complete internally, no extra timing pulses needed.
// - Data outputs float during the data phase of a write.
// - Output drivers are steered internally, not by output enable.
// - Output enable gates the data drivers without the clock.
// - Three synchronous chip selects select the device.
// - Read data flows out in the cycle after the address edge.
// - Bursts follow linear or interleaved address order.
// - Power down on sleep input or on chip-select deselect.
// - Lowest two address bits seed the two-bit burst counter.
// - Advance/load high advances the burst, low loads an address.

package sram_port_pkg;

    // ------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------
    localparam int LANES_WIDE = 4;
    localparam int LANES_NARROW = 2;
    localparam int LANE_BITS = 9;
    localparam int WORD_WIDE = 36;
    localparam int WORD_NARROW = 18;
    localparam int ADDR_BITS_DEFAULT = 10;

    // ------------------------------------------------------------
    // Burst counter and buffer
    // ------------------------------------------------------------
    localparam int BURST_BITS = 2;
    localparam logic [1:0] BURST_STEP_RESET = 2'h0;
    localparam logic [1:0] BUF_COUNT_RESET = 2'h0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : sram_port_pkg

// ---- tb/sram_ctrl_model.sv ----
// Controller model: one access per call, write data one beat later.
// Assumes the bench calls op() between rising clock edges.
`timescale 1ns/100ps

module sram_ctrl_model (
    // Clock
    input wire logic clk,
    // Pins towards the port
    output logic [9:0] addr,
    output logic chip_sel1_n,
    output logic chip_sel2,
    output logic chip_sel3_n,
    output logic write_sel_n,
    output logic [3:0] lane_write_n,
    output logic advance_or_load,
    output logic [35:0] dq_in
);
    logic wkind, wr_pend;
    logic [35:0] d_pend;

    initial begin
        {addr, dq_in, d_pend} = '0;
        {chip_sel1_n, chip_sel2, chip_sel3_n} = 3'h5;
        {write_sel_n, lane_write_n} = 5'h1F;
        {advance_or_load, wkind, wr_pend} = 3'h0;
    end

    task automatic op(input logic sel, adv, wr, input logic [9:0] a,
                      input logic [3:0] ln, input logic [35:0] d);
        @(posedge clk);
        #1;
        chip_sel1_n = ~sel;
        chip_sel2 = sel;
        chip_sel3_n = ~sel;
        advance_or_load = adv;
        write_sel_n = ~wr;
        // Address is a don't-care on advance beats, so keep it moving
        addr = adv ? ~addr : a;
        lane_write_n = ln;
        // Released bus shows a changing pattern, never the last word
        dq_in = wr_pend ? d_pend : ~dq_in;
        if (!adv) begin
            wkind = sel & wr;
        end
        wr_pend = wkind;
        d_pend = d;
    endtask : op
endmodule : sram_ctrl_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the flow-through SRAM port.
// Assumes sram_ctrl_model drives the address, select and data pins.
`timescale 1ns/100ps

module tb_top;
    logic clk, reset, clock_qualify_n, burst_interleave;
    logic output_enable_n, sleep_pin, rd_ready;
    logic [9:0] addr;
    logic chip_sel1_n, chip_sel2, chip_sel3_n, write_sel_n;
    logic advance_or_load, dq_oe, rd_valid, stream_ready, power_down;
    logic [3:0] lane_write_n;
    logic [35:0] dq_in, dq_out, rd_data;
    logic [35:0] mem [0:1023];
    logic [9:0] pa, base;
    logic [3:0] pl;
    logic [35:0] pd;
    logic [1:0] n;
    int num_errors, checks, cyc, pk, k;

    flow_through_sync_sram_port dut (.clk, .reset, .addr, .chip_sel1_n,
        .chip_sel2, .chip_sel3_n, .write_sel_n, .lane_write_n,
        .advance_or_load, .clock_qualify_n, .burst_interleave,
        .output_enable_n, .sleep_pin, .dq_in, .dq_out, .dq_oe, .rd_data,
        .rd_valid, .rd_ready, .stream_ready, .power_down);
    sram_ctrl_model pm (.clk, .addr, .chip_sel1_n, .chip_sel2,
        .chip_sel3_n, .write_sel_n, .lane_write_n, .advance_or_load,
        .dq_in);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            test_done;
        end
    end

    task automatic test_done;
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(string nm, logic [35:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Issue one beat, then judge the data phase of the beat before
    task automatic step(input logic sel, adv, wr, input logic [9:0] a,
                        input logic [3:0] ln, input logic [35:0] d);
        logic [9:0] ea;
        if (!adv) begin
            base = a;
            n = 2'h0;
            k = sel ? (wr ? 2 : 1) : 0;
        end else begin
            n = n + 2'h1;
        end
        ea = {base[9:2], burst_interleave ? base[1:0] ^ n : base[1:0] + n};
        pm.op(sel, adv, wr, a, ln, d);
        if (pk == 2) begin
            for (int i = 0; i < 4; i++) begin
                if (!pl[i]) mem[pa][9*i+:9] = pd[9*i+:9];
            end
        end
        if (pk == 1) check("dq_out", dq_out, mem[pa]);
        check("dq_oe", {35'h0, dq_oe}, {35'h0, pk == 1});
        pk = k;
        pa = ea;
        pl = ln;
        pd = d;
    endtask : step

    task automatic idle;
        step(1'b0, 1'b0, 1'b0, 10'h000, 4'hF, 36'h0);
    endtask : idle

    task automatic s_fill;
        for (int i = 0; i < 8; i++) begin
            step(1'b1, 1'b0, 1'b1, (i < 4) ? 10'(i) : 10'(i + 'h100),
                 4'h0, 36'h123456789 ^ {4{9'(i)}});
        end
        idle;
    endtask : s_fill

    task automatic s_turn;
        step(1'b1, 1'b0, 1'b1, 10'h001, 4'h5, 36'hFFFFFFFFF);
        step(1'b1, 1'b0, 1'b0, 10'h001, 4'hF, 36'h0);
        step(1'b1, 1'b0, 1'b1, 10'h002, 4'hA, 36'h0);
        step(1'b1, 1'b0, 1'b0, 10'h002, 4'hF, 36'h0);
        step(1'b1, 1'b0, 1'b0, 10'h001, 4'hF, 36'h0);
        idle;
    endtask : s_turn

    task automatic s_burst;
        for (int m = 0; m < 2; m++) begin
            burst_interleave = m[0];
            step(1'b1, 1'b0, 1'b0, 10'h105, 4'hF, 36'h0);
            repeat (3) step(1'b1, 1'b1, 1'b0, 10'h0, 4'hF, 36'h0);
            idle;
        end
        burst_interleave = 1'b0;
        step(1'b1, 1'b0, 1'b1, 10'h002, 4'h0, 36'h0F0F0F0F0);
        for (int i = 1; i < 4; i++) begin
            step(1'b1, 1'b1, 1'b1, 10'h0, 4'(i), {4{9'(i * 7)}});
        end
        for (int i = 0; i < 4; i++) begin
            step(1'b1, 1'b0, 1'b0, 10'(i), 4'hF, 36'h0);
        end
        idle;
    endtask : s_burst

    task automatic s_suspend;
        step(1'b1, 1'b0, 1'b0, 10'h104, 4'hF, 36'h0);
        step(1'b1, 1'b0, 1'b0, 10'h105, 4'hF, 36'h0);
        clock_qualify_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("dq_out held", dq_out, mem[10'h104]);
        check("dq_oe held", {35'h0, dq_oe}, 36'h1);
        clock_qualify_n = 1'b0;
        idle;
    endtask : s_suspend

    task automatic s_oe_sleep;
        step(1'b1, 1'b0, 1'b0, 10'h106, 4'hF, 36'h0);
        idle;
        output_enable_n = 1'b1;
        #1;
        check("dq_oe gated", {35'h0, dq_oe}, 36'h0);
        output_enable_n = 1'b0;
        sleep_pin = 1'b1;
        #1;
        check("sleep dq_oe", {35'h0, dq_oe}, 36'h0);
        check("sleep power", {35'h0, power_down}, 36'h1);
        sleep_pin = 1'b0;
        #1;
        check("dq_oe back", {35'h0, dq_oe}, 36'h1);
        step(1'b1, 1'b0, 1'b0, 10'h107, 4'hF, 36'h0);
        check("desel power", {35'h0, power_down}, 36'h1);
        idle;
        check("sel power", {35'h0, power_down}, 36'h0);
        // Sleep held across a load edge must block that access
        sleep_pin = 1'b1;
        step(1'b1, 1'b0, 1'b0, 10'h104, 4'hF, 36'h0);
        @(posedge clk);
        #1;
        check("sleep edge power", {35'h0, power_down}, 36'h1);
        sleep_pin = 1'b0;
        #1;
        check("sleep blocked", {35'h0, dq_oe}, 36'h0);
        idle;
    endtask : s_oe_sleep

    task automatic s_buffer;
        repeat (4) @(posedge clk);
        #1;
        rd_ready = 1'b0;
        step(1'b1, 1'b0, 1'b0, 10'h104, 4'hF, 36'h0);
        step(1'b1, 1'b0, 1'b0, 10'h105, 4'hF, 36'h0);
        idle;
        @(posedge clk);
        #1;
        check("stall", {35'h0, stream_ready}, 36'h0);
        check("head", rd_data, mem[10'h104]);
        rd_ready = 1'b1;
        @(posedge clk);
        #1;
        check("next", rd_data, mem[10'h105]);
        @(posedge clk);
        #1;
        check("drained", {35'h0, rd_valid}, 36'h0);
    endtask : s_buffer

    initial begin
        {reset, rd_ready} = 2'h3;
        {clock_qualify_n, burst_interleave, sleep_pin} = 3'h0;
        output_enable_n = 1'b0;
        {num_errors, checks, cyc, pk, k} = '0;
        {n, base} = '0;
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        s_fill;
        s_turn;
        s_burst;
        s_suspend;
        s_oe_sleep;
        s_buffer;
        test_done;
    end
endmodule : tb_top
